/* dv/abie_chk.sv */
// Purpose: Port-level checks of the ALU and branch execute block
// Assumes: APB slave answers with exactly one wait state
// Notes:   Bound to every abie_core instance
`include "abie_defs.vh"

module abie_chk (
    input logic        i_clk,
    input logic        i_resetn,
    input logic        i_psel,
    input logic        i_penable,
    input logic        i_pwrite,
    input logic [7:0]  i_paddr,
    input logic [31:0] i_pwdata,
    input logic [31:0] o_prdata,
    input logic        o_pready,
    input logic        o_pslverr,
    input logic        o_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    AST_PREADY_WAIT: assert property ((i_psel && !i_penable) |=>
        !o_pready ##1 o_pready) else $error("ready not after one wait");
    AST_PREADY_PULSE: assert property (o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    AST_PREADY_CAUSE: assert property (o_pready |->
        $past(i_psel && i_penable)) else $error("ready without access");
    AST_UNMAPPED_ERR: assert property ((o_pready && i_paddr > 8'h24)
        |-> o_pslverr) else $error("unmapped address not refused");
    AST_MAPPED_OK: assert property ((o_pready && i_paddr <= 8'h24 &&
        i_paddr[1:0] == 2'h0) |-> !o_pslverr) else $error("mapped refused");
    AST_ERR_RDATA: assert property ((o_pready && o_pslverr && !i_pwrite)
        |-> o_prdata == 32'h0) else $error("refused read data not zero");
    AST_ACCUM_WIDTH: assert property ((o_pready && !i_pwrite &&
        i_paddr == `ABIE_OFS_ACCUM) |-> o_prdata[31:8] == 24'h0)
        else $error("accumulator upper bits not zero");
    AST_BUSY_START: assert property ((o_pready && i_pwrite &&
        i_paddr == `ABIE_OFS_INSTR && !o_busy) |=> o_busy)
        else $error("start write did not raise busy");
    AST_BUSY_LEN: assert property ($rose(o_busy) |->
        (o_busy[*4] ##1 !o_busy) or (o_busy[*8] ##1 !o_busy))
        else $error("busy length not four or eight");
endmodule

bind abie_core abie_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_busy(o_busy));

/* dv/tb.sv */
// Purpose: Self-checking bench of the ALU and branch execute block
// Assumes: APB master tasks, one instruction at a time
// Notes:   Expected values worked out by hand per case
`include "abie_defs.vh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk;
    logic        i_resetn;
    logic        i_psel;
    logic        i_penable;
    logic        i_pwrite;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata;
    wire  [31:0] o_prdata;
    wire         o_pready;
    wire         o_pslverr;
    wire         o_busy;
    logic [31:0] rd_data;
    logic        rd_err;
    int          num_errors = 0;
    int          tests_run = 0;
    int          busy_cnt = 0;

    abie_core dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_busy(o_busy));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        if (o_busy === 1'b1) busy_cnt <= busy_cnt + 1;
    end

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task finish_test;
        $display("errors %0d tests %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
            num_errors++;
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        rd_data = o_prdata;
        rd_err = o_pslverr;
        if (o_pready !== 1'b1) num_errors++;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd_data);
    endtask

    task mem_set(input logic [11:0] ad, input logic [7:0] f);
        apb(1'b1, `ABIE_OFS_MEM_ADDR, {20'h0, ad});
        apb(1'b1, `ABIE_OFS_MEM_DATA, {24'h0, f});
    endtask

    task exec(input logic [15:0] ins, input int cyc);
        int n;
        busy_cnt = 0;
        apb(1'b1, `ABIE_OFS_INSTR, {16'h0, ins});
        for (n = 0; n < 20 && (n < 2 || o_busy !== 1'b0); n++)
            @(posedge i_clk);
        chk("cycles", cyc, busy_cnt);
    endtask

    // ALU case: preset accumulator, flags, one file byte; run; check all
    task op(input logic [15:0] ins, input logic [11:0] ad,
            input logic [7:0] w, f, st, ew, ef, est);
        apb(1'b1, `ABIE_OFS_ACCUM, {24'h0, w});
        apb(1'b1, `ABIE_OFS_STATUS, {24'h0, st});
        mem_set(ad, f);
        exec(ins, 4);
        rdchk("accum", `ABIE_OFS_ACCUM, {24'h0, ew});
        rdchk("status", `ABIE_OFS_STATUS, {24'h0, est});
        apb(1'b1, `ABIE_OFS_MEM_ADDR, {20'h0, ad});
        rdchk("file", `ABIE_OFS_MEM_DATA, {24'h0, ef});
    endtask

    // Branch case from pointer 0x0100
    task br(input logic [15:0] ins, input logic [7:0] st,
            input logic [15:0] ep, input int cyc);
        apb(1'b1, `ABIE_OFS_PTR, 32'h100);
        apb(1'b1, `ABIE_OFS_STATUS, {24'h0, st});
        exec(ins, cyc);
        rdchk("pointer", `ABIE_OFS_PTR, {16'h0, ep});
        rdchk("flags", `ABIE_OFS_STATUS, {24'h0, st});
        rdchk("state", `ABIE_OFS_STATE, (cyc == 8) ? 32'h4 : 32'h0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int a;
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        i_resetn = 1'b0;
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (a = 0; a <= 8'h24; a += 4)
            if (a != `ABIE_OFS_MEM_DATA) rdchk("reset", 8'(a), 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, rd_err});
        chk("err data", 32'h0, rd_data);
        apb(1'b1, `ABIE_OFS_BANK, 32'h3);
        op(16'h2745, 12'h345, 8'h17, 8'hc2, 8'h00, 8'h17, 8'hd9, 8'h10);
        op(16'h2445, 12'h045, 8'h17, 8'hc2, 8'h00, 8'hd9, 8'hc2, 8'h10);
        op(16'h2485, 12'hf85, 8'hff, 8'h01, 8'h00, 8'h00, 8'h01, 8'h07);
        op(16'h2145, 12'h345, 8'h4d, 8'h02, 8'h01, 8'h50, 8'h02, 8'h02);
        op(16'h2345, 12'h345, 8'h7f, 8'h00, 8'h01, 8'h7f, 8'h80, 8'h1a);
        op(16'h0b5f, 12'h345, 8'ha3, 8'h55, 8'h1f, 8'h03, 8'h55, 8'h0b);
        op(16'h1745, 12'h345, 8'h17, 8'hc2, 8'h00, 8'h17, 8'h02, 8'h00);
        op(16'h1545, 12'h345, 8'h0f, 8'hf0, 8'h10, 8'h00, 8'hf0, 8'h04);
        op(16'h9f45, 12'h345, 8'h00, 8'hff, 8'h15, 8'h00, 8'h7f, 8'h15);
        op(16'h9045, 12'h045, 8'h00, 8'hff, 8'h0a, 8'h00, 8'hfe, 8'h0a);
        apb(1'b1, `ABIE_OFS_CTRL, 32'h1);
        apb(1'b1, `ABIE_OFS_INDEX, 32'h200);
        op(16'h265f, 12'h25f, 8'h01, 8'h01, 8'h00, 8'h01, 8'h02, 8'h00);
        op(16'h2660, 12'h060, 8'h01, 8'h01, 8'h00, 8'h01, 8'h02, 8'h00);
        apb(1'b1, `ABIE_OFS_PTR, 32'h100);
        exec(16'h0000, 4);
        rdchk("illegal", `ABIE_OFS_STATE, 32'h2);
        rdchk("pointer", `ABIE_OFS_PTR, 32'h102);
        br(16'he205, 8'h1f, 16'h010c, 8);
        br(16'he205, 8'h00, 16'h0102, 4);
        br(16'he380, 8'h00, 16'h0002, 8);
        br(16'he305, 8'h01, 16'h0102, 4);
        br(16'he67f, 8'h10, 16'h0200, 8);
        br(16'he605, 8'h00, 16'h0102, 4);
        br(16'he705, 8'h00, 16'h010c, 8);
        br(16'he705, 8'h10, 16'h0102, 4);
        br(16'he505, 8'h00, 16'h010c, 8);
        br(16'he505, 8'h08, 16'h0102, 4);
        br(16'he105, 8'h00, 16'h010c, 8);
        br(16'he105, 8'h04, 16'h0102, 4);
        finish_test;
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        finish_test;
    end
endmodule

/* include/abie_defs.vh */
// Purpose: Constants of the ALU and branch execute block
// Assumes: Included once by each design file that needs it
// Notes:   Offsets are APB byte addresses
`ifndef ABIE_DEFS_VH
`define ABIE_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ABIE_OFS_CTRL      8'h00
`define ABIE_OFS_INSTR     8'h04
`define ABIE_OFS_ACCUM     8'h08
`define ABIE_OFS_STATUS    8'h0c
`define ABIE_OFS_BANK      8'h10
`define ABIE_OFS_PTR       8'h14
`define ABIE_OFS_INDEX     8'h18
`define ABIE_OFS_MEM_ADDR  8'h1c
`define ABIE_OFS_MEM_DATA  8'h20
`define ABIE_OFS_STATE     8'h24

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ABIE_RST_CTRL      1'b0
`define ABIE_RST_INSTR     16'h0000
`define ABIE_RST_ACCUM     8'h00
`define ABIE_RST_STATUS    5'h00
`define ABIE_RST_BANK      4'h0
`define ABIE_RST_PTR       16'h0000
`define ABIE_RST_INDEX     12'h000
`define ABIE_RST_MEM_ADDR  12'h000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ABIE_FLAG_C        0
`define ABIE_FLAG_DC       1
`define ABIE_FLAG_Z        2
`define ABIE_FLAG_OV       3
`define ABIE_FLAG_N        4
`define ABIE_BIT_DEST      9
`define ABIE_BIT_ACCESS    8
`define ABIE_ST_BUSY       0
`define ABIE_ST_ILLEGAL    1
`define ABIE_ST_TAKEN      2

// ----------------------------------------------------------------
// Opcode patterns and classes
// ----------------------------------------------------------------
`define ABIE_PAT_ADD       6'h09
`define ABIE_PAT_ADDC      6'h08
`define ABIE_PAT_ANDF      6'h05
`define ABIE_PAT_ANDL      8'h0b
`define ABIE_PAT_BCF       4'h9
`define ABIE_PAT_BR        4'he
`define ABIE_BR_C          4'h2
`define ABIE_BR_NC         4'h3
`define ABIE_BR_N          4'h6
`define ABIE_BR_NN         4'h7
`define ABIE_BR_NOV        4'h5
`define ABIE_BR_NZ         4'h1
`define ABIE_CL_ILL        3'h0
`define ABIE_CL_ADD        3'h1
`define ABIE_CL_ADDC       3'h2
`define ABIE_CL_ANDL       3'h3
`define ABIE_CL_ANDF       3'h4
`define ABIE_CL_BCF        3'h5
`define ABIE_CL_BR         3'h6

// ----------------------------------------------------------------
// Addressing and timing
// ----------------------------------------------------------------
`define ABIE_INDEX_LIMIT   8'h5f
`define ABIE_LOW_BANK      4'h0
`define ABIE_HIGH_BANK     4'hf
`define ABIE_PTR_STEP      16'h0002
`define ABIE_Q_LAST        2'h3
`define ABIE_Q_READ        2'h2

`endif

/* logic/abie_core.v */
// Purpose: Decode and execute of add, AND, bit clear and branch ops
// Assumes: APB slave on i_clk, one instruction per start write
// Notes:   Each instruction cycle is four clock phases
`include "abie_defs.vh"

module abie_core (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_resetn,
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    // Status
    output reg         o_busy
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_EXEC = 2'h1;
    localparam [1:0] ST_NOP  = 2'h2;

    reg        ext_en_reg;
    reg [15:0] instr_reg;
    reg [7:0]  accum_reg;
    reg [4:0]  flags_reg;
    reg [3:0]  bank_select_register;
    reg [15:0] instruction_pointer;
    reg [11:0] index_base_reg;
    reg [11:0] mem_addr_reg;
    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [1:0]  phase_reg;
    reg [7:0]  result_reg;
    reg [4:0]  res_flags_reg;
    reg        illegal_reg;
    reg        taken_reg;

    wire        acc_edge;
    wire        wr_edge;
    wire        start;
    wire [2:0]  op_class;
    wire [11:0] exec_addr;
    wire [11:0] port_addr;
    wire        port_wen;
    wire [7:0]  port_wdata;
    wire [7:0]  file_data;
    wire        dest_file;
    wire        cond;
    wire [15:0] br_ofs;
    reg [8:0]  sum9;
    reg [7:0]  alu_res;
    reg [4:0]  alu_flags;
    reg [31:0] rd_mux;
    reg        rd_hit;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function [2:0] classify;
        input [15:0] ins;
        begin
            if (ins[15:10] == `ABIE_PAT_ADD) begin
                classify = `ABIE_CL_ADD;
            end else if (ins[15:10] == `ABIE_PAT_ADDC) begin
                classify = `ABIE_CL_ADDC;
            end else if (ins[15:10] == `ABIE_PAT_ANDF) begin
                classify = `ABIE_CL_ANDF;
            end else if (ins[15:8] == `ABIE_PAT_ANDL) begin
                classify = `ABIE_CL_ANDL;
            end else if (ins[15:12] == `ABIE_PAT_BCF) begin
                classify = `ABIE_CL_BCF;
            end else if (ins[15:12] == `ABIE_PAT_BR &&
                         (ins[11:8] == `ABIE_BR_C  ||
                          ins[11:8] == `ABIE_BR_NC ||
                          ins[11:8] == `ABIE_BR_N  ||
                          ins[11:8] == `ABIE_BR_NN ||
                          ins[11:8] == `ABIE_BR_NOV ||
                          ins[11:8] == `ABIE_BR_NZ)) begin
                classify = `ABIE_CL_BR;
            end else begin
                classify = `ABIE_CL_ILL;
            end
        end
    endfunction

    function branch_cond;
        input [3:0] sel;
        input [4:0] fl;
        begin
            case (sel)
                `ABIE_BR_C:   branch_cond = fl[`ABIE_FLAG_C];
                `ABIE_BR_NC:  branch_cond = ~fl[`ABIE_FLAG_C];
                `ABIE_BR_N:   branch_cond = fl[`ABIE_FLAG_N];
                `ABIE_BR_NN:  branch_cond = ~fl[`ABIE_FLAG_N];
                `ABIE_BR_NOV: branch_cond = ~fl[`ABIE_FLAG_OV];
                `ABIE_BR_NZ:  branch_cond = ~fl[`ABIE_FLAG_Z];
                default:      branch_cond = 1'b0;
            endcase
        end
    endfunction

    function [11:0] file_address;
        input [7:0]  f;
        input        acc;
        input        ext;
        input [3:0]  bank;
        input [11:0] base;
        begin
            if (acc) begin
                file_address = {bank, f};
            end else if (ext && f <= `ABIE_INDEX_LIMIT) begin
                file_address = base + {4'h0, f};
            end else if (f[7]) begin
                file_address = {`ABIE_HIGH_BANK, f};
            end else begin
                file_address = {`ABIE_LOW_BANK, f};
            end
        end
    endfunction

    function [7:0] clear_mask;
        input [2:0] pos;
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                clear_mask[k] = (pos != k[2:0]);
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    assign acc_edge  = i_psel & i_penable & o_pready;
    assign wr_edge   = acc_edge & i_pwrite;
    assign start     = wr_edge & (i_paddr == `ABIE_OFS_INSTR) &
                       (state_reg == ST_IDLE);
    assign op_class  = classify(instr_reg);
    assign dest_file = (instr_reg[`ABIE_BIT_DEST] &
                        (op_class != `ABIE_CL_ANDL)) |
                       (op_class == `ABIE_CL_BCF);
    assign cond      = branch_cond(instr_reg[11:8], flags_reg);
    assign br_ofs    = {{7{instr_reg[7]}}, instr_reg[7:0], 1'b0};
    assign exec_addr = file_address(instr_reg[7:0],
                                    instr_reg[`ABIE_BIT_ACCESS],
                                    ext_en_reg,
                                    bank_select_register,
                                    index_base_reg);

    // ----------------------------------------------------------------
    // File register port
    // ----------------------------------------------------------------
    assign port_addr  = (state_reg == ST_IDLE) ? mem_addr_reg : exec_addr;
    assign port_wen   = (state_reg == ST_EXEC && phase_reg == `ABIE_Q_LAST &&
                         dest_file &&
                         (op_class == `ABIE_CL_ADD ||
                          op_class == `ABIE_CL_ADDC ||
                          op_class == `ABIE_CL_ANDF ||
                          op_class == `ABIE_CL_BCF)) ||
                        (state_reg == ST_IDLE && wr_edge &&
                         i_paddr == `ABIE_OFS_MEM_DATA);
    assign port_wdata = (state_reg == ST_IDLE) ? i_pwdata[7:0] : result_reg;

    abie_file_mem u_general_register_bank (
        .i_clk   (i_clk),
        .i_addr  (port_addr),
        .i_wen   (port_wen),
        .i_wdata (port_wdata),
        .o_rdata (file_data)
    );

    // ----------------------------------------------------------------
    // Arithmetic and logic
    // ----------------------------------------------------------------
    always @* begin
        sum9      = 9'h000;
        alu_res   = file_data;
        alu_flags = flags_reg;
        case (op_class)
            `ABIE_CL_ADD, `ABIE_CL_ADDC: begin
                sum9   = {1'b0, accum_reg} + {1'b0, file_data} +
                         {8'h00, (op_class == `ABIE_CL_ADDC) &
                                 flags_reg[`ABIE_FLAG_C]};
                alu_res = sum9[7:0];
                alu_flags[`ABIE_FLAG_C]  = sum9[8];
                alu_flags[`ABIE_FLAG_DC] = sum9[4] ^ accum_reg[4] ^
                                           file_data[4];
                alu_flags[`ABIE_FLAG_Z]  = (sum9[7:0] == 8'h00);
                alu_flags[`ABIE_FLAG_OV] = (accum_reg[7] == file_data[7]) &
                                           (sum9[7] != accum_reg[7]);
                alu_flags[`ABIE_FLAG_N]  = sum9[7];
            end
            `ABIE_CL_ANDL, `ABIE_CL_ANDF: begin
                alu_res = (op_class == `ABIE_CL_ANDL) ?
                          (accum_reg & instr_reg[7:0]) :
                          (accum_reg & file_data);
                alu_flags[`ABIE_FLAG_Z] = (alu_res == 8'h00);
                alu_flags[`ABIE_FLAG_N] = alu_res[7];
            end
            `ABIE_CL_BCF: begin
                alu_res = file_data & clear_mask(instr_reg[11:9]);
            end
            default: alu_flags = flags_reg;
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: state_next = start ? ST_EXEC : ST_IDLE;
            ST_EXEC: begin
                if (phase_reg == `ABIE_Q_LAST) begin
                    state_next = (op_class == `ABIE_CL_BR && cond) ?
                                 ST_NOP : ST_IDLE;
                end
            end
            ST_NOP:
                state_next = (phase_reg == `ABIE_Q_LAST) ? ST_IDLE : ST_NOP;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg     <= ST_IDLE;
            phase_reg     <= 2'h0;
            result_reg    <= 8'h00;
            res_flags_reg <= `ABIE_RST_STATUS;
            illegal_reg   <= 1'b0;
            taken_reg     <= 1'b0;
            o_busy        <= 1'b0;
        end else begin
            state_reg <= state_next;
            o_busy    <= (state_next != ST_IDLE);
            phase_reg <= (state_reg == ST_IDLE) ? 2'h0 : phase_reg + 2'h1;
            if (start) begin
                illegal_reg <= 1'b0;
                taken_reg   <= 1'b0;
            end
            if (state_reg == ST_EXEC && phase_reg == `ABIE_Q_READ) begin
                result_reg    <= alu_res;
                res_flags_reg <= alu_flags;
            end
            if (state_reg == ST_EXEC && phase_reg == `ABIE_Q_LAST) begin
                illegal_reg <= (op_class == `ABIE_CL_ILL);
                taken_reg   <= (op_class == `ABIE_CL_BR) & cond;
            end
        end
    end

    // ----------------------------------------------------------------
    // Architectural registers
    // ----------------------------------------------------------------
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_en_reg           <= `ABIE_RST_CTRL;
            instr_reg            <= `ABIE_RST_INSTR;
            accum_reg            <= `ABIE_RST_ACCUM;
            flags_reg            <= `ABIE_RST_STATUS;
            bank_select_register <= `ABIE_RST_BANK;
            instruction_pointer  <= `ABIE_RST_PTR;
            index_base_reg       <= `ABIE_RST_INDEX;
            mem_addr_reg         <= `ABIE_RST_MEM_ADDR;
        end else if (state_reg == ST_IDLE) begin
            // Software writes land only while no instruction runs
            if (wr_edge) begin
                case (i_paddr)
                    `ABIE_OFS_CTRL:     ext_en_reg <= i_pwdata[0];
                    `ABIE_OFS_INSTR:    instr_reg <= i_pwdata[15:0];
                    `ABIE_OFS_ACCUM:    accum_reg <= i_pwdata[7:0];
                    `ABIE_OFS_STATUS:   flags_reg <= i_pwdata[4:0];
                    `ABIE_OFS_BANK:     bank_select_register <= i_pwdata[3:0];
                    `ABIE_OFS_PTR:
                        instruction_pointer <= {i_pwdata[15:1], 1'b0};
                    `ABIE_OFS_INDEX:    index_base_reg <= i_pwdata[11:0];
                    `ABIE_OFS_MEM_ADDR: mem_addr_reg <= i_pwdata[11:0];
                    default:            ext_en_reg <= ext_en_reg;
                endcase
            end
        end else if (state_reg == ST_EXEC) begin
            if (phase_reg == 2'h0) begin
                // Fetch of the next word advances the pointer
                instruction_pointer <= instruction_pointer + `ABIE_PTR_STEP;
            end
            if (phase_reg == `ABIE_Q_LAST) begin
                if (op_class == `ABIE_CL_BR && cond) begin
                    instruction_pointer <=
                        instruction_pointer + br_ofs;
                end
                if (op_class != `ABIE_CL_ILL &&
                    op_class != `ABIE_CL_BR &&
                    op_class != `ABIE_CL_BCF && !dest_file) begin
                    accum_reg <= result_reg;
                end
                flags_reg <= res_flags_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // APB read data and handshake
    // ----------------------------------------------------------------
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (i_paddr)
            `ABIE_OFS_CTRL:     rd_mux[0] = ext_en_reg;
            `ABIE_OFS_INSTR:    rd_mux[15:0] = instr_reg;
            `ABIE_OFS_ACCUM:    rd_mux[7:0] = accum_reg;
            `ABIE_OFS_STATUS:   rd_mux[4:0] = flags_reg;
            `ABIE_OFS_BANK:     rd_mux[3:0] = bank_select_register;
            `ABIE_OFS_PTR:      rd_mux[15:0] = instruction_pointer;
            `ABIE_OFS_INDEX:    rd_mux[11:0] = index_base_reg;
            `ABIE_OFS_MEM_ADDR: rd_mux[11:0] = mem_addr_reg;
            `ABIE_OFS_MEM_DATA: rd_mux[7:0] = file_data;
            `ABIE_OFS_STATE: begin
                rd_mux[`ABIE_ST_BUSY]    = (state_reg != ST_IDLE);
                rd_mux[`ABIE_ST_ILLEGAL] = illegal_reg;
                rd_mux[`ABIE_ST_TAKEN]   = taken_reg;
            end
            default:            rd_hit = 1'b0;
        endcase
    end

    // One wait state so memory data settle after an address write
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel & i_penable & ~o_pready;
            o_pslverr <= i_psel & i_penable & ~o_pready & ~rd_hit;
            if (i_psel & i_penable & ~o_pready) begin
                o_prdata <= i_pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

endmodule

/* logic/abie_file_mem.v */
// Purpose: File register memory, one port, registered read
// Assumes: Write and read share one address per cycle
// Notes:   Read data follow the address by one clock edge
module abie_file_mem (
    // Clock
    input  wire        i_clk,
    // Port
    input  wire [11:0] i_addr,
    input  wire        i_wen,
    input  wire [7:0]  i_wdata,
    output reg  [7:0]  o_rdata
);

    reg [7:0] mem_reg [0:4095];

    always @(posedge i_clk) begin
        if (i_wen) begin
            mem_reg[i_addr] <= i_wdata;
        end
        o_rdata <= mem_reg[i_addr];
    end

endmodule
